// [include/wtg_defines.vh]
// Register map, field positions, reset values and mode codes for the 8-bit waveform timer.
`ifndef WTG_DEFINES_VH
`define WTG_DEFINES_VH
`define WTG_OFS_CONTROL   4'h0
`define WTG_OFS_COUNT     4'h4
`define WTG_OFS_COMPARE   4'h8
`define WTG_OFS_STATUS    4'hc
`define WTG_BIT_FORCE     7
`define WTG_BIT_MODE_LO   6
`define WTG_BIT_ACT_HI    5
`define WTG_BIT_ACT_LO    4
`define WTG_BIT_MODE_HI   3
`define WTG_BIT_CS_HI     2
`define WTG_BIT_OVF       0
`define WTG_BIT_MATCH     1
`define WTG_CONTROL_RST   8'h00
`define WTG_COUNT_MAX     8'hff
`define WTG_COUNT_BOTTOM  8'h00
`define WTG_MODE_NORMAL   2'h0
`define WTG_MODE_PHASE    2'h1
`define WTG_MODE_CLEAR    2'h2
`define WTG_MODE_FAST     2'h3
`define WTG_RESP_OKAY     2'h0
`define WTG_RESP_SLVERR   2'h2
`endif

// [hdl/wtg_timer.v]
// Waveform timer core with AXI4-Lite register slave.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "wtg_defines.vh"
module wtg_timer (
  input  wire        clk_in,           // System clock, 100 MHz.
  input  wire        sys_rst_in,       // Asynchronous reset, active high.
  input  wire        tick_in,          // Timer tick enable from the prescaler.
  input  wire        s_axi_awvalid,    // Write address valid.
  output reg         s_axi_awready,    // Write address ready.
  input  wire [3:0]  s_axi_awaddr,     // Write byte address.
  input  wire        s_axi_wvalid,     // Write data valid.
  output reg         s_axi_wready,     // Write data ready.
  input  wire [31:0] s_axi_wdata,      // Write data.
  input  wire [3:0]  s_axi_wstrb,      // Write byte strobes.
  output reg         s_axi_bvalid,     // Write response valid.
  input  wire        s_axi_bready,     // Write response ready.
  output reg  [1:0]  s_axi_bresp,      // Write response code.
  input  wire        s_axi_arvalid,    // Read address valid.
  output reg         s_axi_arready,    // Read address ready.
  input  wire [3:0]  s_axi_araddr,     // Read byte address.
  output reg         s_axi_rvalid,     // Read data valid.
  input  wire        s_axi_rready,     // Read data ready.
  output reg  [31:0] s_axi_rdata,      // Read data.
  output reg  [1:0]  s_axi_rresp,      // Read response code.
  output reg         wave_out_out,     // Waveform output level.
  output reg         wave_oe_out,      // Waveform output connected to the pin.
  output reg         overflow_flag_out,// Sticky overflow flag.
  output reg         match_flag_out    // Sticky compare match flag.
);

  // ********************************************************************
  // Register storage and decode
  // ********************************************************************
  reg  [7:0] control;
  reg  [7:0] count_value;
  reg  [7:0] compare_value;
  // Compare value seen by the match logic; a written value waits in the buffer.
  reg  [7:0] compare_active;
  reg        count_up;
  // Set by a count write to mask the match on the next tick.
  reg        block_match;
  reg        aw_held;
  reg        w_held;
  reg  [3:0] aw_addr;
  reg  [7:0] w_data;
  reg        w_lane0;
  reg        next_wave;

  // Returns one-hot hit on control, count, compare, status; zero when unmapped.
  function [3:0] reg_hit;
    input [3:0] addr;
    begin
      case (addr)
        `WTG_OFS_CONTROL: reg_hit = 4'h1;
        `WTG_OFS_COUNT:   reg_hit = 4'h2;
        `WTG_OFS_COMPARE: reg_hit = 4'h4;
        `WTG_OFS_STATUS:  reg_hit = 4'h8;
        default:          reg_hit = 4'h0;
      endcase
    end
  endfunction

  wire [1:0] wave_mode_sel     = {control[`WTG_BIT_MODE_HI], control[`WTG_BIT_MODE_LO]};
  wire [1:0] output_action_sel = control[`WTG_BIT_ACT_HI:`WTG_BIT_ACT_LO];
  // The prescaler lives outside; a stopped clock select masks every tick, so the
  // count and the flags freeze, while a forced compare can still move the output.
  wire       clock_running     = control[`WTG_BIT_CS_HI:0] != 3'h0;
  wire       timer_tick_enable = tick_in && clock_running;
  // The forced compare and the immediate compare update belong to the other modes.
  wire       is_pwm            = wave_mode_sel == `WTG_MODE_PHASE || wave_mode_sel == `WTG_MODE_FAST;
  // A write lands only once both halves are held and the previous answer has gone.
  // Holding them lets address and data arrive in either order.
  wire       wr_now            = aw_held && w_held && !s_axi_bvalid;
  wire [3:0] wr_hit            = reg_hit(aw_addr) & {4{wr_now && w_lane0}};
  wire       at_max            = count_value == `WTG_COUNT_MAX;
  wire       at_bottom         = count_value == `WTG_COUNT_BOTTOM;
  wire       cmp_max           = compare_active == `WTG_COUNT_MAX;
  wire       cmp_eq            = count_value == compare_active;
  // A count write suppresses the match on the following tick.
  wire       match_hit         = timer_tick_enable && cmp_eq && !block_match;
  wire       force_hit         = wr_hit[0] && w_data[`WTG_BIT_FORCE] && !is_pwm;
  // Phase correct levels: clear on the way up for code 2, set for code 3.
  // Both levels follow from bit 0 alone, since code 1 is filtered out by bit 1.
  wire       up_level          = output_action_sel[0];
  wire       down_level        = !output_action_sel[0];

  // ********************************************************************
  // Waveform output next state
  // ********************************************************************
  always @* begin
    next_wave = wave_out_out;
    case (wave_mode_sel)
      `WTG_MODE_NORMAL, `WTG_MODE_CLEAR: begin
        // A forced compare acts like a match on the output only.
        if (match_hit || force_hit) begin
          case (output_action_sel)
            2'h1:    next_wave = !wave_out_out;
            2'h2:    next_wave = 1'b0;
            2'h3:    next_wave = 1'b1;
            default: next_wave = wave_out_out;
          endcase
        end
      end
      `WTG_MODE_FAST: begin
        // The bottom action is taken on the tick that wraps MAX to BOTTOM, so it lands
        // together with the new count. It is checked first, which makes a compare of MAX
        // a steady level instead of a one-tick glitch.
        if (timer_tick_enable && at_max && output_action_sel[1]) begin
          next_wave = !output_action_sel[0];
        end else if (match_hit && output_action_sel == 2'h1) begin
          next_wave = !wave_out_out;
        end else if (match_hit && output_action_sel[1] && !cmp_max) begin
          next_wave = output_action_sel[0];
        end
      end
      `WTG_MODE_PHASE: begin
        // Action code 1 is reserved here and leaves the output alone.
        if (timer_tick_enable && output_action_sel[1]) begin
          if (count_up) begin
            if (at_max && cmp_max) begin
              next_wave = down_level;
            end else if (count_value >= compare_active && !block_match) begin
              // Catches a count that starts above the compare value.
              next_wave = up_level;
            end
          end else begin
            if (at_bottom) begin
              // Period start: a zero compare holds the up level all period.
              next_wave = (compare_active == `WTG_COUNT_BOTTOM) ? up_level : down_level;
            end else if (cmp_eq && !block_match) begin
              // On the way down the match restores the level that the up slope took away.
              next_wave = down_level;
            end
          end
        end
      end
      default: next_wave = wave_out_out;
    endcase
  end

  // ********************************************************************
  // Waveform output register
  // ********************************************************************
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wave_out_out <= 1'b0;
      wave_oe_out  <= 1'b0;
    end else begin
      // Registered so the pin never sees a glitch from the match logic.
      wave_out_out <= next_wave;
      // The pin is handed to the waveform only while an action is selected.
      wave_oe_out  <= output_action_sel != 2'h0;
    end
  end

  // ********************************************************************
  // Control and compare registers
  // ********************************************************************
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      control       <= `WTG_CONTROL_RST;
      compare_value <= `WTG_COUNT_BOTTOM;
    end else begin
      // The strobe bit is never stored, so it reads back as zero.
      if (wr_hit[0]) begin
        control <= {1'b0, w_data[6:0]};
      end
      if (wr_hit[2]) begin
        compare_value <= w_data;
      end
    end
  end

  // ********************************************************************
  // Active compare value
  // ********************************************************************
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      compare_active <= `WTG_COUNT_BOTTOM;
    end else begin
      // Modes without double buffering copy the buffer every clock, one clock late.
      // The pulse modes copy only at the turning point, so that a period never sees
      // two different compare values.
      // Compare update point per mode.
      case (wave_mode_sel)
        `WTG_MODE_FAST: begin
          if (timer_tick_enable && at_max) begin
            compare_active <= compare_value;
          end
        end
        `WTG_MODE_PHASE: begin
          if (timer_tick_enable && at_max && count_up) begin
            compare_active <= compare_value;
          end
        end
        default: compare_active <= compare_value;
      endcase
    end
  end

  // ********************************************************************
  // Counter
  // ********************************************************************
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_value <= `WTG_COUNT_BOTTOM;
      count_up    <= 1'b1;
      block_match <= 1'b0;
    end else begin
      // A count write wins over the tick in the same cycle and blocks the next match,
      // so software can preload the count without a stray edge on the output.
      if (wr_hit[1]) begin
        count_value <= w_data;
        block_match <= 1'b1;
      end else if (timer_tick_enable) begin
        block_match <= 1'b0;
        case (wave_mode_sel)
          `WTG_MODE_PHASE: begin
            // Count stands at MAX for one tick, then turns.
            if (count_up) begin
              count_value <= at_max ? count_value - 8'h01 : count_value + 8'h01;
              count_up    <= !at_max;
            end else begin
              count_value <= at_bottom ? count_value + 8'h01 : count_value - 8'h01;
              count_up    <= at_bottom;
            end
          end
          `WTG_MODE_CLEAR: begin
            // A compare below the current count is missed and the count wraps through MAX.
            // Only a real match clears, never a forced one.
            count_value <= (cmp_eq && !block_match) ? `WTG_COUNT_BOTTOM : count_value + 8'h01;
          end
          default: count_value <= count_value + 8'h01;
        endcase
      end
      if (wave_mode_sel != `WTG_MODE_PHASE) begin
        count_up <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Sticky flags
  // ********************************************************************
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      overflow_flag_out <= 1'b0;
      match_flag_out    <= 1'b0;
    end else begin
      // Software clears a flag by writing one to its bit in the status register.
      // Hardware set wins over a same-cycle write-one clear.
      if (timer_tick_enable && ((wave_mode_sel == `WTG_MODE_PHASE) ? (!count_up && at_bottom) : at_max)) begin
        overflow_flag_out <= 1'b1;
      end else if (wr_hit[3] && w_data[`WTG_BIT_OVF]) begin
        overflow_flag_out <= 1'b0;
      end
      if (match_hit) begin
        match_flag_out <= 1'b1;
      end else if (wr_hit[3] && w_data[`WTG_BIT_MATCH]) begin
        match_flag_out <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // AXI4-Lite write channel
  // ********************************************************************
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WTG_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Only byte lane 0 carries a register; a write without that lane is answered
      // OKAY but leaves the register alone.
      // An unmapped address is refused with SLVERR and changes nothing.
      if (wr_now) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_hit(aw_addr) == 4'h0) ? `WTG_RESP_SLVERR : `WTG_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // AXI4-Lite read channel
  // ********************************************************************
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `WTG_RESP_OKAY;
    end else begin
      // Reads have no side effects, so a read is answered in the cycle after it is
      // taken, whatever the write channel is doing.
      // Compare reads return the buffer, not the active copy, so software sees what it wrote.
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= (reg_hit(s_axi_araddr) == 4'h0) ? `WTG_RESP_SLVERR : `WTG_RESP_OKAY;
        case (reg_hit(s_axi_araddr))
          4'h1:    s_axi_rdata <= {24'h000000, 1'b0, control[6:0]};
          4'h2:    s_axi_rdata <= {24'h000000, count_value};
          4'h4:    s_axi_rdata <= {24'h000000, compare_value};
          4'h8:    s_axi_rdata <= {30'h00000000, match_flag_out, overflow_flag_out};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// [tb/wtg_timer_monitor.sv]
// Checker on the ports of the waveform timer.
`timescale 1ns/1ps
`include "wtg_defines.vh"
module wtg_timer_monitor (
  input wire        clk_in, sys_rst_in, tick_in,
  input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb,
  input wire [31:0] s_axi_wdata, s_axi_rdata,
  input wire [1:0]  s_axi_bresp, s_axi_rresp,
  input wire        wave_out_out, wave_oe_out, overflow_flag_out, match_flag_out
);
  logic [3:0] rd_addr;
  logic [3:0] wr_addr;
  logic [7:0] wr_byte;
  logic [7:0] ctl_copy;
  wire        ctl_done = s_axi_bvalid && s_axi_bready && wr_addr == `WTG_OFS_CONTROL;
  // The copy lags the real register, so a write still in flight never counts as stopped.
  wire        stopped  = ctl_copy[2:0] == 3'h0 && s_axi_awready;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_addr <= 4'h0;
      wr_addr <= 4'h0;
      wr_byte <= 8'h00;
      ctl_copy <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wr_byte <= s_axi_wdata[7:0];
      if (ctl_done) ctl_copy <= wr_byte;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2]) else $error("address reopened");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  force_read_a:
    assert property (s_axi_rvalid && rd_addr == `WTG_OFS_CONTROL |-> !s_axi_rdata[`WTG_BIT_FORCE])
    else $error("force bit read as one");
  rd_err_a: assert property (s_axi_rvalid && rd_addr[1:0] != 2'h0 |-> s_axi_rresp == `WTG_RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  oe_follow_a: assert property (ctl_done |=> wave_oe_out == (ctl_copy[5:4] != 2'h0)) else $error("enable wrong");
  flags_quiet_a:
    assert property (stopped && $past(stopped) |-> !$rose(match_flag_out) && !$rose(overflow_flag_out))
    else $error("flag set while stopped");
  wave_still_a:
    assert property (stopped && $past(stopped) |-> $stable(wave_out_out)) else $error("wave moved while stopped");
  cover property (ctl_done && wr_byte[`WTG_BIT_FORCE]);
  cover property (ctl_done && wr_byte[6] && !wr_byte[3]);
  cover property (s_axi_rvalid && s_axi_rresp == `WTG_RESP_SLVERR);
endmodule

// [tb/wtg_timer_bench.sv]
// Self-checking bench for the waveform timer.
`timescale 1ns/1ps
`include "wtg_defines.vh"
module wtg_timer_bench;
  typedef struct {logic [7:0] ctl; logic [7:0] cmp; int len; int hi; int rises;} wtg_row_t;
  logic        clk_in = 1'b0;
  logic        sys_rst_in, tick_in;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
  logic        wave_out_out, wave_oe_out, overflow_flag_out, match_flag_out, w0;
  int          fail_count = 0;
  int          n_tests = 0;
  int          hi, rs;
  // High time and rising edges are counted over two periods, which holds for any start phase.
  wtg_row_t    rows [10] = '{
    '{8'h61, 8'h40, 510, 128, 1}, '{8'h71, 8'h40, 510, 382, 1}, '{8'h61, 8'h00, 510, 0, 0},
    '{8'h61, 8'hff, 510, 510, 0}, '{8'h71, 8'h00, 510, 510, 0}, '{8'h69, 8'h00, 256, 1, 1},
    '{8'h69, 8'h80, 256, 129, 1}, '{8'h69, 8'hff, 256, 256, 0}, '{8'h79, 8'hff, 256, 0, 0},
    '{8'h59, 8'h80, 512, 256, 1}};
  wtg_timer dut (.*);
  always #5 clk_in = ~clk_in;
  task automatic chk_v(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_n(input string s, input int e, input int g);
    n_tests++;
    if (g != e) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic meas(input int len, output int h, output int r);
    logic p;
    h = 0;
    r = 0;
    p = wave_out_out;
    repeat (len) begin
      @(posedge clk_in);
      h += (wave_out_out === 1'b1);
      r += (wave_out_out === 1'b1 && p === 1'b0);
      p = wave_out_out;
    end
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    {sys_rst_in, tick_in, s_axi_wstrb} = 6'h3f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      rd(a[3:0], rd_data, rd_resp);
      chk_v("reset value", 32'h0, rd_data);
    end
    rd(4'h2, rd_data, rd_resp);
    chk_v("unmapped resp", {30'h0, `WTG_RESP_SLVERR}, {30'h0, rd_resp});
    foreach (rows[i]) begin
      wr(`WTG_OFS_COMPARE, rows[i].cmp);
      wr(`WTG_OFS_CONTROL, rows[i].ctl);
      repeat (3 * rows[i].len) @(posedge clk_in);
      meas(2 * rows[i].len, hi, rs);
      chk_n("high ticks", 2 * rows[i].hi, hi);
      chk_n("rising edges", 2 * rows[i].rises, rs);
      chk_v("output enable", 32'h1, {31'h0, wave_oe_out});
    end
    wr(`WTG_OFS_CONTROL, 8'h61);
    wr(`WTG_OFS_STATUS, 8'h03);
    repeat (520) @(posedge clk_in);
    chk_v("overflow", 32'h1, {31'h0, overflow_flag_out});
    wr(`WTG_OFS_CONTROL, 8'h10);
    wr(`WTG_OFS_STATUS, 8'h03);
    wr(`WTG_OFS_COUNT, 8'h20);
    tick_in <= 1'b0;
    wr(`WTG_OFS_CONTROL, 8'h19);
    repeat (20) @(posedge clk_in);
    rd(`WTG_OFS_COUNT, rd_data, rd_resp);
    chk_v("count idle", 32'h20, rd_data);
    w0 = wave_out_out;
    wr(`WTG_OFS_CONTROL, 8'h99);
    @(posedge clk_in);
    chk_v("forced wave", {31'h0, ~w0}, {31'h0, wave_out_out});
    chk_v("forced match", 32'h0, {31'h0, match_flag_out});
    rd(`WTG_OFS_COUNT, rd_data, rd_resp);
    chk_v("count kept", 32'h20, rd_data);
    rd(`WTG_OFS_CONTROL, rd_data, rd_resp);
    chk_v("control", 32'h19, rd_data);
    wr(`WTG_OFS_CONTROL, 8'h69);
    w0 = wave_out_out;
    wr(`WTG_OFS_CONTROL, 8'he9);
    @(posedge clk_in);
    chk_v("pulse force", {31'h0, w0}, {31'h0, wave_out_out});
    tick_in <= 1'b1;
    wr(`WTG_OFS_CONTROL, 8'h19);
    wr(`WTG_OFS_COMPARE, 8'h30);
    wr(`WTG_OFS_STATUS, 8'h03);
    repeat (300) @(posedge clk_in);
    chk_v("match flag", 32'h1, {31'h0, match_flag_out});
    rd(`WTG_OFS_COUNT, rd_data, rd_resp);
    chk_n("count below top", 1, int'(rd_data <= 32'h30));
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    fail_count++;
    print_verdict();
  end
endmodule
bind wtg_timer wtg_timer_monitor mon (.*);
